/* File: sim/module_sideband_control_tb.sv */
// bench joining module and host ends, random and corner stimulus
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %b exp %b", $time, g, e); end end
module module_sideband_control_tb;
  import msc_pkg::*;
  localparam int DONE = 5;
  logic clk, rst, mgmt_req, mgmt_ack_req, fault_event, int_clear;
  int   sreset_count = 0;
  int   sreset_base;
  logic select_req, reset_req, low_power_req, module_absent, irq_seen;
  logic mgmt_enable, mgmt_ack_drive, low_power, data_not_ready, settings_reset;
  logic fault_pending, status_valid, reset_busy;
  int   bad_count, checked, seed, n;
  msc_if pins ();
  msc_device #(.PULSE_CYC(2), .DONE_CYC(DONE), .BOOT_CYC(DONE)) u_msc_device (
    .clk, .rst, .pins(pins), .mgmt_req, .mgmt_ack_req, .fault_event, .int_clear,
    .mgmt_enable, .mgmt_ack_drive, .low_power, .data_not_ready, .settings_reset,
    .fault_pending);
  msc_host #(.PULSE_CYC(4)) u_msc_host (.clk, .rst, .pins(pins), .select_req,
    .reset_req, .low_power_req, .module_absent, .irq_seen, .status_valid, .reset_busy);
  msc_checker #(.PULSE_CYC(2), .DONE_CYC(DONE), .BOOT_CYC(DONE), .H_PULSE(4)) u_msc_checker (
    .clk, .rst, .sel_o(pins.sel_o), .sel_oe(pins.sel_oe), .rst_o(pins.rst_o),
    .rst_oe(pins.rst_oe), .lp_oe(pins.lp_oe), .int_o(pins.int_o), .int_oe(pins.int_oe),
    .prs_oe(pins.prs_oe), .module_reset_n(pins.module_reset_n),
    .module_present_n(pins.module_present_n));
  // clock of 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count settings restore pulses outside power-on reset
  always @(posedge clk) if (settings_reset === 1'b1 && !rst) sreset_count <= sreset_count + 1;
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("counts: %0d checked, %0d bad", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for the interrupt line to go low
  task automatic wait_int(input int lim, output int cnt);
    cnt = 0;
    while (pins.interrupt_out_n !== 1'b0 && cnt < lim) begin
      step(1);
      cnt++;
    end
    if (cnt >= lim) begin
      bad_count++;
      give_verdict();
    end
  endtask
  // one-cycle pulses on fault and clear
  task automatic pulse(input logic f, input logic c);
    @(posedge clk);
    fault_event <= f;
    int_clear   <= c;
    @(posedge clk);
    fault_event <= 1'b0;
    int_clear   <= 1'b0;
    step(2);
  endtask
  // main sequence
  initial begin
    seed = 40651;
    {rst, mgmt_req, mgmt_ack_req, fault_event, int_clear} = 5'h10;
    {select_req, reset_req, low_power_req, bad_count, checked} = '0;
    step(6);
    `CHK(pins.module_select_n, 1'b1)
    `CHK(mgmt_enable, 1'b0)
    @(posedge clk) rst <= 1'b0;
    wait_int(DONE + 10, n);
    step(2);
    `CHK(status_valid, 1'b1)
    `CHK(irq_seen, 1'b1)
    `CHK(data_not_ready, 1'b0)
    `CHK(module_absent, 1'b0)
    $display("boot test done");
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      select_req    <= 1'($random(seed));
      low_power_req <= 1'($random(seed));
      mgmt_req      <= 1'($random(seed));
      mgmt_ack_req  <= 1'($random(seed));
      step(3);
      `CHK(mgmt_enable, select_req)
      `CHK(pins.module_select_n, ~select_req)
      `CHK(mgmt_ack_drive, select_req & mgmt_req & mgmt_ack_req)
      `CHK(low_power, low_power_req)
    end
    $display("select test done");
    pulse(1'b0, 1'b1);
    `CHK(pins.interrupt_out_n, 1'b1)
    pulse(1'b1, 1'b0);
    `CHK(pins.interrupt_out_n, 1'b0)
    pulse(1'b1, 1'b1);
    `CHK(fault_pending, 1'b1)
    pulse(1'b0, 1'b1);
    `CHK(fault_pending, 1'b0)
    `CHK(pins.interrupt_out_n, 1'b1)
    $display("fault test done");
    sreset_base = sreset_count;
    @(posedge clk);
    select_req <= 1'b1;
    reset_req  <= 1'b1;
    @(posedge clk) reset_req <= 1'b0;
    n = 0;
    while (pins.module_reset_n !== 1'b0 && n < 10) begin
      step(1);
      n++;
    end
    `CHK(pins.module_reset_n, 1'b0)
    step(2);
    `CHK(mgmt_enable, 1'b0)
    while (pins.module_reset_n !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    `CHK(pins.module_reset_n, 1'b1)
    step(2);
    `CHK(data_not_ready, 1'b1)
    `CHK(reset_busy, 1'b1)
    `CHK(sreset_count > sreset_base, 1'b1)
    `CHK(pins.interrupt_out_n, 1'b1)
    wait_int(DONE + 10, n);
    `CHK(n + 2 >= DONE, 1'b1)
    step(2);
    `CHK(data_not_ready, 1'b0)
    `CHK(status_valid, 1'b1)
    $display("reset test done");
    @(posedge clk) rst <= 1'b1;
    step(3);
    `CHK(pins.interrupt_out_n, 1'b1)
    @(posedge clk) rst <= 1'b0;
    wait_int(DONE + 10, n);
    $display("second power-up test done");
    give_verdict();
  end
endmodule

/* File: sim/msc_checker.sv */
// assertions on the sideband pins between module and host ends
`timescale 1ns/100ps
module msc_checker #(
  parameter int unsigned PULSE_CYC = 2,
  parameter int unsigned DONE_CYC  = 5,
  parameter int unsigned BOOT_CYC  = 5,
  parameter int unsigned H_PULSE   = 4
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_o,
  input wire logic sel_oe,
  input wire logic rst_o,
  input wire logic rst_oe,
  input wire logic lp_oe,
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic prs_oe,
  input wire logic module_reset_n,
  input wire logic module_present_n
);
  localparam int DONE_LIM = int'(DONE_CYC) + 6;
  localparam int BOOT_LIM = int'(BOOT_CYC) + 6;
  int low_cnt;
  int hi_cnt;
  // run lengths of reset low at the module and of the host reset drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 0;
      hi_cnt  <= 0;
    end else begin
      low_cnt <= module_reset_n ? 0 : low_cnt + 1;
      hi_cnt  <= rst_oe ? hi_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_present; !module_present_n && prs_oe; endproperty
  a_present: assert property (p_present) else $error("presence not grounded");
  property p_int_oc; int_o == 1'b0; endproperty
  a_int_oc: assert property (p_int_oc) else $error("interrupt drives high");
  property p_sel_low; sel_oe |-> !sel_o; endproperty
  a_sel_low: assert property (p_sel_low) else $error("select driven high");
  property p_rst_low; rst_oe |-> !rst_o; endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset driven high");
  property p_lp; lp_oe; endproperty
  a_lp: assert property (p_lp) else $error("low power undriven");
  property p_boot; $fell(rst) && module_reset_n |-> ##[1:BOOT_LIM] int_oe; endproperty
  a_boot: assert property (p_boot) else $error("no power-up interrupt");
  property p_done;
    $rose(module_reset_n) && low_cnt > PULSE_CYC |-> ##[1:DONE_LIM] int_oe;
  endproperty
  a_done: assert property (p_done) else $error("no reset completion");
  property p_hpulse; $fell(rst_oe) |-> hi_cnt == int'(H_PULSE); endproperty
  a_hpulse: assert property (p_hpulse) else $error("host pulse length");
endmodule

/* File: src/msc_device.sv */
// module end of the sideband control: select gating, reset, low power, flags
// Notes on behaviour
// [RULE1] select low: management traffic is answered
// [RULE2] select high: management bus fully ignored
// [RULE3] host lowers only the addressed select
// [RULE4] select pulled up, undriven means deselected
// [RULE5] long reset low restores all defaults
// [RULE6] completion time counts from reset rise
// [RULE7] host ignores status until completion
// [RULE8] completion clears pending flag, pulls interrupt
// [RULE9] power-up raises completion interrupt unaided
// [RULE10] low-power input high enters reduced power
// [RULE11] presence pin grounded inside module
// [RULE12] interrupt low flags fault or critical status
// [RULE13] host reads status to find cause
// [RULE14] interrupt open collector, host pull-up
// [RULE15] fully functional within 2000 ms
// [RULE16] host reads low page flag field
// [RULE17] reset pulse and completion times are parameters
`timescale 1ns/100ps
module msc_device
  import msc_pkg::*;
#(
  parameter int unsigned PULSE_CYC = msc_pkg::RST_PULSE_CYC,  // [RULE17]
  parameter int unsigned DONE_CYC  = msc_pkg::RST_DONE_CYC,
  parameter int unsigned BOOT_CYC  = msc_pkg::RST_DONE_CYC
)(
  input  wire logic clk,
  input  wire logic rst,
  msc_if.dev        pins,
  input  wire logic mgmt_req,
  input  wire logic mgmt_ack_req,
  input  wire logic fault_event,
  input  wire logic int_clear,
  output logic      mgmt_enable,
  output logic      mgmt_ack_drive,
  output logic      low_power,
  output logic      data_not_ready,
  output logic      settings_reset,
  output logic      fault_pending
);
  import msc_pkg::*;

  // reset sequencer state and its cycle counter
  msc_state_t       state;
  msc_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  // initialisation pending flag, completion interrupt and fault flag
  logic             pend;
  logic             next_pend;
  logic             irq;
  logic             next_irq;
  logic             flt;
  logic             next_flt;

  // management gating and acknowledge permission
  logic             en;
  logic             next_en;
  logic             ack;
  logic             next_ack;

  // low power level and settings restore pulse
  logic             lp;
  logic             next_lp;
  logic             sreset;
  logic             next_sreset;

  // open-drain interrupt drive, registered so the pin comes from a flop
  logic             int_drive;
  logic             next_int_drive;

  // reset pin seen low
  logic             rst_low;

  // minimum reset low time reached; the held counter saturates there
  function automatic logic pulse_met(input logic [CNT_W-1:0] c);
    pulse_met = (c >= CNT_W'(PULSE_CYC));
  endfunction

  // pin inputs are taken as synchronous to clk
  assign rst_low = !pins.module_reset_n;

  // reset sequencer and flags, next values
  // the low time must reach the minimum pulse before a restore is taken
  always_comb begin
    // hold by default; a new fault event always raises its flag
    next_state  = state;
    next_cnt    = cnt;
    next_pend   = pend;
    next_irq    = irq;
    next_flt    = flt || fault_event;
    next_sreset = 1'b0;
    unique case (state)
      // idle: a low reset pin starts the pulse count
      MSC_IDLE: begin
        if (rst_low) begin
          next_state = MSC_HELD;
          next_cnt   = '0;
        end
      end
      // held: count the low time, saturating at the minimum pulse
      MSC_HELD: begin
        if (rst_low) begin
          if (!pulse_met(cnt)) begin
            next_cnt = cnt + CNT_W'(1);
          end
        end else if (pulse_met(cnt)) begin
          // long enough: restore defaults, time completion from the rise
          next_state  = MSC_INIT;  // [RULE6]
          next_cnt    = '0;
          next_pend   = 1'b1;
          next_irq    = 1'b0;
          next_flt    = fault_event;
          next_sreset = 1'b1;  // [RULE5]
        end else begin
          // too short: no reset is taken
          next_state = MSC_IDLE;  // short glitch ignored
        end
      end
      // executing: a new low restarts, otherwise count to completion
      MSC_INIT: begin
        if (rst_low) begin
          next_state = MSC_HELD;
          next_cnt   = '0;
        end else if (cnt + CNT_W'(1) >= CNT_W'(DONE_CYC)) begin
          next_state = MSC_DONE;
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
      // completion: drop the pending flag, raise the interrupt
      MSC_DONE: begin
        next_pend  = 1'b0;  // [RULE8]
        next_irq   = 1'b1;  // [RULE8] [RULE9]
        next_state = MSC_IDLE;
      end
    endcase
    // clear from management loses to a new event
    // the completion cycle sets the interrupt itself, so a clear in that cycle is ignored
    if (int_clear && state != MSC_DONE) begin
      next_irq = 1'b0;
      next_flt = fault_event;
    end
  end

  // management is served only while selected and no reset is held or executing
  // a deselected module never lets the 2-wire core drive the bus
  function automatic logic is_serving(input msc_state_t s, input logic sel_n);
    is_serving = !sel_n && (s == MSC_IDLE);
  endfunction

  // management gating, low power and interrupt drive, next values
  always_comb begin
    next_en        = is_serving(state, pins.module_select_n);  // [RULE1] [RULE4]
    next_ack       = next_en && mgmt_ack_req && mgmt_req;  // [RULE2]
    next_lp        = pins.low_power_select;  // [RULE10]
    next_int_drive = next_irq || next_flt;  // [RULE12]
  end

  // registers of the reset sequencer; power-up enters completion timing on its own
  // the counter starts so that boot waits BOOT_CYC cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state  <= MSC_INIT;  // [RULE9] [RULE15]
      cnt    <= CNT_W'(DONE_CYC - BOOT_CYC);
      pend   <= PEND_RESET;
      irq    <= 1'b0;
      flt    <= 1'b0;
      sreset <= 1'b1;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      pend   <= next_pend;
      irq    <= next_irq;
      flt    <= next_flt;
      sreset <= next_sreset;
    end
  end

  // registers of the gating, low power and pin drive
  // the interrupt enable is a flop so the pin never glitches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en        <= 1'b0;
      ack       <= 1'b0;
      lp        <= 1'b0;
      int_drive <= 1'b0;
    end else begin
      en        <= next_en;
      ack       <= next_ack;
      lp        <= next_lp;
      int_drive <= next_int_drive;
    end
  end

  // open-drain interrupt: value always low, enable pulls the line
  assign pins.int_o      = 1'b0;  // [RULE14]
  assign pins.int_oe     = int_drive;  // [RULE12]
  // presence pin grounded for as long as the module is seated
  assign pins.prs_o      = 1'b0;  // [RULE11]
  assign pins.prs_oe     = 1'b1;
  // management side outputs
  assign mgmt_enable     = en;
  assign mgmt_ack_drive  = ack;
  // status side outputs
  assign low_power       = lp;
  assign data_not_ready  = pend;
  assign settings_reset  = sreset;
  assign fault_pending   = flt;
endmodule

/* File: src/msc_host.sv */
// host end of the sideband control: select, reset pulse, low power, status
`timescale 1ns/100ps
module msc_host
  import msc_pkg::*;
#(
  parameter int unsigned PULSE_CYC = msc_pkg::HOST_PULSE_CYC  // [RULE17]
)(
  input  wire logic clk,
  input  wire logic rst,
  msc_if.host       pins,
  input  wire logic select_req,
  input  wire logic reset_req,
  input  wire logic low_power_req,
  output logic      module_absent,
  output logic      irq_seen,
  output logic      status_valid,
  output logic      reset_busy
);
  import msc_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             busy;
  logic             next_busy;
  logic             drv;
  logic             next_drv;
  logic             valid;
  logic             next_valid;
  logic             sel;
  logic             next_sel;
  logic             lp;
  logic             next_lp;
  logic             absent;
  logic             next_absent;
  logic             irq;
  logic             next_irq;

  // reset pulse timing and status validity
  always_comb begin
    next_cnt    = cnt;
    next_busy   = busy;
    next_drv    = drv;
    next_valid  = valid;
    next_irq    = !pins.interrupt_out_n;  // [RULE13] [RULE16]
    next_absent = pins.module_present_n;
    next_sel    = select_req;  // [RULE3]
    next_lp     = low_power_req;
    if (!busy && reset_req) begin
      next_busy  = 1'b1;
      next_drv   = 1'b1;
      next_cnt   = '0;
      next_valid = 1'b0;  // [RULE7]
    end else if (drv) begin
      if (cnt + CNT_W'(1) >= CNT_W'(PULSE_CYC)) begin
        next_drv = 1'b0;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end else if (busy && next_irq && !irq) begin  // fresh interrupt only, not a stale one
      next_busy  = 1'b0;
      next_valid = 1'b1;
    end
  end

  // registers; after power-up wait for the completion interrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt    <= '0;
      busy   <= 1'b1;
      drv    <= 1'b0;
      valid  <= 1'b0;
      sel    <= 1'b0;
      lp     <= 1'b0;
      absent <= 1'b1;
      irq    <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      busy   <= next_busy;
      drv    <= next_drv;
      valid  <= next_valid;
      sel    <= next_sel;
      lp     <= next_lp;
      absent <= next_absent;
      irq    <= next_irq;
    end
  end

  // pin drives; open-drain reset driven low only
  assign pins.sel_o   = 1'b0;
  assign pins.sel_oe  = sel;
  assign pins.rst_o   = 1'b0;
  assign pins.rst_oe  = drv;
  assign pins.lp_o    = lp;
  assign pins.lp_oe   = 1'b1;
  assign module_absent = absent;
  assign irq_seen      = irq;
  assign status_valid  = valid;
  assign reset_busy    = busy;
endmodule

/* File: src/msc_if.sv */
// interface joining module and host sideband pins
`timescale 1ns/100ps
interface msc_if;
  logic sel_o;     // host drives select low level
  logic sel_oe;    // host drives select
  logic rst_o;     // host reset drive
  logic rst_oe;
  logic lp_o;      // host low-power drive
  logic lp_oe;
  logic int_o;     // module interrupt open-drain output (value, always 0)
  logic int_oe;    // module pulls interrupt low
  logic prs_o;     // module presence pin value
  logic prs_oe;    // module grounds presence
  // resolved wires, pull-ups on host board / module, low power pulled low when undriven
  logic module_select_n;
  logic module_reset_n;
  logic low_power_select;
  logic interrupt_out_n;
  logic module_present_n;
  assign module_select_n  = sel_oe ? sel_o : 1'b1;
  assign module_reset_n   = rst_oe ? rst_o : 1'b1;
  assign low_power_select = lp_oe ? lp_o : 1'b0;
  assign interrupt_out_n  = int_oe ? int_o : 1'b1;
  assign module_present_n = prs_oe ? prs_o : 1'b1;
  modport dev (
    input  module_select_n, module_reset_n, low_power_select,
    output int_o, int_oe, prs_o, prs_oe
  );
  modport host (
    input  interrupt_out_n, module_present_n,
    output sel_o, sel_oe, rst_o, rst_oe, lp_o, lp_oe
  );
endinterface

/* File: src/msc_pkg.sv */
// package of constants and types for the module sideband control link
package msc_pkg;
  // clock rate
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  // power-on initialisation time, longest, in ms
  localparam int unsigned INIT_TIME_MS    = 2000;
  localparam int unsigned INIT_CYCLES     = INIT_TIME_MS * (CLK_HZ / 1000);
  // default minimum reset pulse and completion time, in us
  localparam int unsigned RST_PULSE_US    = 10;
  localparam int unsigned RST_PULSE_CYC   = (RST_PULSE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned RST_DONE_US     = 100;
  localparam int unsigned RST_DONE_CYC    = (RST_DONE_US * CLK_HZ) / 1_000_000;
  // host reset pulse length it generates, in cycles
  localparam int unsigned HOST_PULSE_CYC  = RST_PULSE_CYC + 2;
  // counter width
  localparam int unsigned CNT_W           = 32;
  // value after reset of the pending flag
  localparam logic        PEND_RESET      = 1'b1;

  // module reset sequencer states, gray along the usual path
  typedef enum logic [1:0] {
    MSC_IDLE  = 2'b00,
    MSC_HELD  = 2'b01,
    MSC_INIT  = 2'b11,
    MSC_DONE  = 2'b10
  } msc_state_t;
endpackage
